/* src/alert_unit_params.svh */
// Register offsets, field positions and reset values of the limit status and alert unit
`ifndef ALERT_UNIT_PARAMS_SVH
`define ALERT_UNIT_PARAMS_SVH

// Register offsets on the management bus register port
`define STATUS_PRI_ADDR   8'h41
`define STATUS_SEC_ADDR   8'h42
`define MASK_PRI_ADDR     8'h74
`define MASK_SEC_ADDR     8'h75
`define CONFIG_THREE_ADDR 8'h78

// Field positions
`define PENDING_BIT       7
`define MASK_ENABLE_BIT   7
`define ALERT_SELECT_BIT  0
`define TEMP_R2_BIT       6
`define TEMP_LOCAL_BIT    5
`define TEMP_R1_BIT       4
`define VOLT_5V_BIT       3
`define VOLT_SUPPLY_BIT   2
`define VOLT_CORE_BIT     1
`define VOLT_2V5_BIT      0
`define DIODE_TWO_BIT     7
`define DIODE_ONE_BIT     6
`define FAN_FIRST_BIT     2
`define OVERTEMP_BIT      1
`define VOLT_12V_BIT      0

// Channel index of the 12 V reading within the eight window channels
`define CHAN_12V          7

// Reset value and the value read at unmapped offsets
`define REG_RESET         8'h00
`define READ_UNMAPPED     8'h00

`endif

/* src/alert_unit_pkg.sv */
// Types shared by the limit status and alert unit
package alert_unit_pkg;
    typedef logic [7:0] reg_byte_t;              // One register
    typedef logic [7:0][7:0] window_bus_t;       // Eight 8-bit channels
    typedef logic [3:0][15:0] tach_bus_t;        // Four 16-bit fan values

    // One-hot register select
    typedef enum logic [5:0] {
        SEL_NONE   = 6'h01,
        SEL_STAT1  = 6'h02,
        SEL_STAT2  = 6'h04,
        SEL_MASK1  = 6'h08,
        SEL_MASK2  = 6'h10,
        SEL_CFG3   = 6'h20
    } reg_sel_t;
endpackage : alert_unit_pkg

/* src/limit_check.sv */
// One high/low limit comparator
`timescale 1ns/1ns
`default_nettype none
module limit_check (
    limit_check_if.cmp lc
);
    // High is strictly above, low includes equality
    always_comb begin
        lc.out_of_limit = (lc.reading > lc.high_limit) ||
                          (lc.low_used && (lc.reading <= lc.low_limit));
    end
endmodule : limit_check
`default_nettype wire

/* src/limit_check_if.sv */
// Carrier between the unit and one limit comparator
`timescale 1ns/1ns
`default_nettype none
interface limit_check_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] reading;       // Latest measured value
    logic [WIDTH-1:0] high_limit;    // Upper limit
    logic [WIDTH-1:0] low_limit;     // Lower limit
    logic             low_used;      // Channel has a low limit
    logic             out_of_limit;  // Comparison result

    modport cmp  (input reading, high_limit, low_limit, low_used, output out_of_limit);
    modport user (output reading, high_limit, low_limit, low_used, input out_of_limit);
endinterface : limit_check_if
`default_nettype wire

/* src/limit_status_alert_unit.sv */
// Sticky limit status registers, alert masks and alert pin select
`timescale 1ns/1ns
`default_nettype none
`include "alert_unit_params.svh"
module limit_status_alert_unit (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // Register port from the two-wire bus engine
    input  wire logic [7:0]                 reg_addr,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [7:0]                 reg_wdata,
    output logic [7:0]                      reg_rdata,
    // Readings and limits of the eight window channels
    input  wire alert_unit_pkg::window_bus_t window_reading,
    input  wire alert_unit_pkg::window_bus_t window_high,
    input  wire alert_unit_pkg::window_bus_t window_low,
    // Fan tach periods and their limits
    input  wire alert_unit_pkg::tach_bus_t  tach_period,
    input  wire alert_unit_pkg::tach_bus_t  tach_limit,
    // Fault flags from the measurement engine
    input  wire logic                       diode_one_fault,
    input  wire logic                       diode_two_fault,
    input  wire logic                       overtemp_flag,
    // Pulse generator output sharing the pin
    input  wire logic                       pwm_in,
    output logic                            alert_n,
    output logic                            second_pulse_output
);
    import alert_unit_pkg::*;

    logic [7:0]  window_oor;     // Window channels out of limit
    logic [3:0]  fan_oor;        // Fans below minimum speed
    reg_byte_t   cond_pri;       // Live primary sources
    reg_byte_t   cond_sec;       // Live secondary sources
    reg_byte_t   stat1_q, stat1_d;
    reg_byte_t   stat2_q, stat2_d;
    reg_byte_t   mask1_q, mask1_d;
    reg_byte_t   mask2_q, mask2_d;
    reg_byte_t   cfg3_q,  cfg3_d;
    reg_byte_t   rdata_q, rdata_d;
    logic        alert_n_q, alert_n_d;
    logic        pin_q, pin_d;
    reg_sel_t    sel;            // Decoded register
    reg_byte_t   stat1_view;     // Primary status as read

    // Register address decode
    function automatic reg_sel_t decode(input logic [7:0] addr);
        case (addr)
            `STATUS_PRI_ADDR:   decode = SEL_STAT1;
            `STATUS_SEC_ADDR:   decode = SEL_STAT2;
            `MASK_PRI_ADDR:     decode = SEL_MASK1;
            `MASK_SEC_ADDR:     decode = SEL_MASK2;
            `CONFIG_THREE_ADDR: decode = SEL_CFG3;
            default:            decode = SEL_NONE;
        endcase
    endfunction : decode

    // Sticky update: set wins, read clears only ended conditions
    function automatic reg_byte_t sticky(input reg_byte_t cur, input reg_byte_t cond, input logic rd);
        sticky = cond | (rd ? 8'h00 : cur);
    endfunction : sticky

    // Window channel comparators
    for (genvar i = 0; i < 8; i++) begin : g_window
        limit_check_if #(.WIDTH(8)) wl ();
        assign wl.reading    = window_reading[i];
        assign wl.high_limit = window_high[i];
        assign wl.low_limit  = window_low[i];
        assign wl.low_used   = 1'b1;
        assign window_oor[i] = wl.out_of_limit;
        limit_check u_cmp (.lc(wl.cmp));
    end

    // Fan comparators; a longer period means a slower fan, high limit only
    for (genvar f = 0; f < 4; f++) begin : g_fan
        limit_check_if #(.WIDTH(16)) fl ();
        assign fl.reading    = tach_period[f];
        assign fl.high_limit = tach_limit[f];
        assign fl.low_limit  = 16'h0000;
        assign fl.low_used   = 1'b0;
        assign fan_oor[f]    = fl.out_of_limit;
        limit_check u_cmp (.lc(fl.cmp));
    end

    // Map live conditions onto status bit positions
    always_comb begin
        cond_pri = window_oor[6:0] & 8'h7f;
        cond_pri[`PENDING_BIT] = 1'b0;                                // Summary bit, not a source
        cond_sec = 8'h00;
        cond_sec[`DIODE_TWO_BIT] = diode_two_fault;
        cond_sec[`DIODE_ONE_BIT] = diode_one_fault;
        cond_sec[`FAN_FIRST_BIT +: 4] = fan_oor;
        cond_sec[`OVERTEMP_BIT] = overtemp_flag;
        cond_sec[`VOLT_12V_BIT] = window_oor[`CHAN_12V];
    end

    // One decode shared by reads and writes, so both see the same map
    assign sel = decode(reg_addr);

    // Primary read view; top bit summarises the secondary register
    always_comb begin
        stat1_view = stat1_q;
        stat1_view[`PENDING_BIT] = |stat2_q;
    end

    // Status and configuration next values
    always_comb begin
        // Status always tracks its sources, mask gating does not apply here
        stat1_d = sticky(stat1_q, cond_pri, reg_rd && (sel == SEL_STAT1));
        stat2_d = sticky(stat2_q, cond_sec, reg_rd && (sel == SEL_STAT2));
        mask1_d = mask1_q;
        mask2_d = mask2_q;
        cfg3_d  = cfg3_q;
        if (reg_wr) begin
            case (sel)
                SEL_MASK1: mask1_d = reg_wdata;
                SEL_MASK2: mask2_d = reg_wdata;
                SEL_CFG3:  cfg3_d  = reg_wdata;
                default:   ;                                          // Status is read only
            endcase
        end
    end

    // Read data, alert and pin next values
    always_comb begin
        case (sel)
            SEL_STAT1: rdata_d = stat1_view;
            SEL_STAT2: rdata_d = stat2_q;
            SEL_MASK1: rdata_d = mask1_q;
            SEL_MASK2: rdata_d = mask2_q;
            SEL_CFG3:  rdata_d = cfg3_q;
            default:   rdata_d = `READ_UNMAPPED;
        endcase
        if (!reg_rd) begin
            rdata_d = rdata_q;                                        // Hold last answer
        end
        // Alert follows sticky status, so it stays low until the read
        alert_n_d = !((|(stat1_q[6:0] & ~mask1_q[6:0])) ||
                      (|(stat2_q & ~(mask1_q[`MASK_ENABLE_BIT] ? mask2_q : 8'h00))));
        // Pin defaults to the pulse output
        pin_d = cfg3_q[`ALERT_SELECT_BIT] ? alert_n_d : pwm_in;
    end

    // Register all state
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat1_q   <= `REG_RESET;
            stat2_q   <= `REG_RESET;
            mask1_q   <= `REG_RESET;
            mask2_q   <= `REG_RESET;
            cfg3_q    <= `REG_RESET;
            rdata_q   <= `REG_RESET;
            alert_n_q <= 1'b1;
            pin_q     <= 1'b0;
        end else begin
            stat1_q   <= stat1_d;
            stat2_q   <= stat2_d;
            mask1_q   <= mask1_d;
            mask2_q   <= mask2_d;
            cfg3_q    <= cfg3_d;
            rdata_q   <= rdata_d;
            alert_n_q <= alert_n_d;
            pin_q     <= pin_d;
        end
    end

    // Outputs come straight from flip-flops, no glitches on the pin
    assign reg_rdata           = rdata_q;
    assign alert_n             = alert_n_q;
    assign second_pulse_output = pin_q;

    // Checks; all on the one clock, quiet while reset is held
    // Each label line names the rule that it guards
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_read_pri_ended;
        reg_rd && (sel == SEL_STAT1) && !window_oor[0];
    endsequence

    sequence s_sec_held;
        stat2_q[`OVERTEMP_BIT] && !(reg_rd && (sel == SEL_STAT2));
    endsequence

    // A status read; a clear applies only to bits whose source has gone
    sequence s_read_pri;
        reg_rd && (sel == SEL_STAT1);
    endsequence

    sequence s_read_sec;
        reg_rd && (sel == SEL_STAT2);
    endsequence

    // A mask write; the new value must show on the next edge
    sequence s_write_mask1;
        reg_wr && (sel == SEL_MASK1);
    endsequence

    sequence s_write_mask2;
        reg_wr && (sel == SEL_MASK2);
    endsequence

    chk_pending_bit: assert property (s_read_pri |=> reg_rdata[`PENDING_BIT] == $past(|stat2_q))
        else $error("pending bit disagrees with secondary status");
    chk_temp_set: assert property (window_oor[6] |=> stat1_q[`TEMP_R2_BIT])
        else $error("remote two flag not set");
    chk_volt_set: assert property (window_oor[3] |=> stat1_q[`VOLT_5V_BIT])
        else $error("5V flag not set");
    chk_diode_set: assert property (diode_two_fault |=> stat2_q[`DIODE_TWO_BIT])
        else $error("diode two flag not set");
    chk_fan_set: assert property (fan_oor[0] |=> stat2_q[`FAN_FIRST_BIT])
        else $error("fan one flag not set");
    chk_overtemp_set: assert property (overtemp_flag |=> stat2_q[`OVERTEMP_BIT])
        else $error("overtemperature flag not set");
    chk_sticky_hold: assert property (s_sec_held |=> stat2_q[`OVERTEMP_BIT])
        else $error("status bit cleared without read");
    chk_read_clear: assert property (s_read_pri_ended |=> !stat1_q[`VOLT_2V5_BIT])
        else $error("ended condition not cleared by read");
    chk_alert_low: assert property (stat1_q[`TEMP_LOCAL_BIT] && !mask1_q[`TEMP_LOCAL_BIT] |=> !alert_n)
        else $error("alert not low for unmasked status");
    chk_mask_only: assert property (
        diode_two_fault && mask2_q[`DIODE_TWO_BIT] && mask1_q[`MASK_ENABLE_BIT] |=> stat2_q[`DIODE_TWO_BIT])
        else $error("masked source did not set status");
    chk_mask_enable: assert property (
        !mask1_q[`MASK_ENABLE_BIT] && stat2_q[`DIODE_TWO_BIT] |=> !alert_n)
        else $error("secondary mask acted while disabled");
    chk_quiet_alert: assert property ((stat1_q[6:0] & ~mask1_q[6:0]) == 7'h00 && stat2_q == 8'h00 |=> alert_n)
        else $error("alert low with nothing unmasked");
    chk_high_strict: assert property (window_reading[`VOLT_5V_BIT] == window_high[`VOLT_5V_BIT]
        && window_reading[`VOLT_5V_BIT] > window_low[`VOLT_5V_BIT] |-> !window_oor[`VOLT_5V_BIT])
        else $error("equality flagged as high violation");
    chk_pin_mux: assert property (!cfg3_q[`ALERT_SELECT_BIT] |=> second_pulse_output == $past(pwm_in))
        else $error("pin not passing pulse output");
    chk_mask_reset: assert property (@(posedge mclk) disable iff (1'b0)
        $fell(rst) |-> mask1_q == 8'h00 && mask2_q == 8'h00)
        else $error("masks not zero after reset");

    // Further source positions, each set one edge after its condition
    chk_local_set: assert property (window_oor[`TEMP_LOCAL_BIT] |=> stat1_q[`TEMP_LOCAL_BIT])
        else $error("local temperature flag not set");
    chk_remote_one_set: assert property (window_oor[`TEMP_R1_BIT] |=> stat1_q[`TEMP_R1_BIT])
        else $error("remote one flag not set");
    chk_core_set: assert property (window_oor[`VOLT_CORE_BIT] |=> stat1_q[`VOLT_CORE_BIT])
        else $error("core supply flag not set");
    chk_supply_set: assert property (window_oor[`VOLT_SUPPLY_BIT] |=> stat1_q[`VOLT_SUPPLY_BIT])
        else $error("supply flag not set");
    chk_diode_one_set: assert property (diode_one_fault |=> stat2_q[`DIODE_ONE_BIT])
        else $error("diode one flag not set");
    chk_fan_four_set: assert property (fan_oor[3] |=> stat2_q[`FAN_FIRST_BIT + 3])
        else $error("fan four flag not set");
    chk_12v_set: assert property (window_oor[`CHAN_12V] |=> stat2_q[`VOLT_12V_BIT])
        else $error("12V flag not set");

    // A read during a live fault keeps the bit; a read after it ends clears
    chk_read_under_fault: assert property (
        s_read_pri ##0 window_oor[`TEMP_LOCAL_BIT] |=> stat1_q[`TEMP_LOCAL_BIT])
        else $error("status bit cleared during live fault");
    chk_sec_read_clear: assert property (s_read_sec ##0 (cond_sec == 8'h00) |=> stat2_q == 8'h00)
        else $error("secondary status not cleared by read");

    // Secondary sources drive the alert unless both mask levels allow gating
    chk_alert_sec: assert property (
        stat2_q[`DIODE_TWO_BIT] && !(mask1_q[`MASK_ENABLE_BIT] && mask2_q[`DIODE_TWO_BIT]) |=> !alert_n)
        else $error("alert not low for unmasked secondary status");
    chk_sec_mask_gate: assert property (
        mask1_q[`MASK_ENABLE_BIT] && ((stat1_q[6:0] & ~mask1_q[6:0]) == 7'h00) && ((stat2_q & ~mask2_q) == 8'h00)
        |=> alert_n)
        else $error("alert low with all secondary sources masked");

    // Shared pin in alert mode carries the alert level
    chk_pin_alert: assert property (cfg3_q[`ALERT_SELECT_BIT] |=> second_pulse_output == alert_n)
        else $error("pin not showing alert");

    // Register port: masks store writes, reads return them, data holds between reads
    chk_mask1_write: assert property (s_write_mask1 |=> mask1_q == $past(reg_wdata))
        else $error("primary mask write lost");
    chk_mask2_write: assert property (s_write_mask2 |=> mask2_q == $past(reg_wdata))
        else $error("secondary mask write lost");
    chk_mask_readback: assert property (reg_rd && (sel == SEL_MASK2) |=> reg_rdata == $past(mask2_q))
        else $error("secondary mask read back wrong");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (reg_rd && (sel == SEL_NONE) |=> reg_rdata == `READ_UNMAPPED)
        else $error("unmapped read not zero");

    // Comparator edges: equality trips a low limit but never a high one
    chk_low_equal: assert property (window_reading[`VOLT_CORE_BIT] == window_low[`VOLT_CORE_BIT]
        |-> window_oor[`VOLT_CORE_BIT])
        else $error("equality missed as low violation");
    chk_fan_strict: assert property (tach_period[0] == tach_limit[0] |-> !fan_oor[0])
        else $error("fan equal to limit flagged slow");
endmodule : limit_status_alert_unit
`default_nettype wire

/* test/host_model.sv */
// Host controller model driving the register port
`timescale 1ns/1ns
`default_nettype none
`include "alert_unit_params.svh"
module host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output var logic  [7:0] reg_addr,
    output var logic        reg_wr,
    output var logic        reg_rd,
    output var logic  [7:0] reg_wdata
);
    // Strobes low from time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // Write pulse; idle fields flip so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr
    // Read pulse; data is registered, taken a cycle on
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask : rd
    // Alert service: read status, then mask every source
    task automatic service(output logic [7:0] s1, output logic [7:0] s2);
        rd(`STATUS_PRI_ADDR, s1);
        rd(`STATUS_SEC_ADDR, s2);
        wr(`MASK_PRI_ADDR, 8'hff);
        wr(`MASK_SEC_ADDR, 8'hff);
    endtask : service
    // Poll status; unmask only once both registers read clear
    task automatic poll_unmask(output logic [7:0] s1);
        logic [7:0] s2;
        rd(`STATUS_SEC_ADDR, s2);
        rd(`STATUS_PRI_ADDR, s1);
        if (s1 == 8'h00 && s2 == 8'h00) begin
            wr(`MASK_PRI_ADDR, 8'h00);
            wr(`MASK_SEC_ADDR, 8'h00);
        end
    endtask : poll_unmask
endmodule : host_model
`default_nettype wire

/* test/limit_status_alert_unit_tb.sv */
// Self-checking bench of the limit status and alert unit
`timescale 1ns/1ns
`default_nettype none
`include "alert_unit_params.svh"
`define CHECK_EQ(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
    $display("Error %s expected %h seen %h", nm, exp, got); err_total++; end end
module limit_status_alert_unit_tb;
    import alert_unit_pkg::*;
    typedef struct packed {int src; bit lo; reg_byte_t e1; reg_byte_t e2;} row_t;
    logic        mclk, rst, reg_wr, reg_rd, pwm_in, alert_n, pin;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d1, d2;
    logic        diode_one_fault, diode_two_fault, overtemp_flag;
    window_bus_t window_reading, window_high, window_low;
    tach_bus_t   tach_period, tach_limit;
    int          err_total  = 0;  // Mismatches
    int          n_compared = 0;  // Comparisons
    // Source, low-limit case, expected primary and secondary status
    row_t rows[15] = '{'{0,0,8'h01,8'h00}, '{1,1,8'h02,8'h00}, '{2,0,8'h04,8'h00}, '{3,1,8'h08,8'h00},
        '{4,0,8'h10,8'h00}, '{5,1,8'h20,8'h00}, '{6,0,8'h40,8'h00}, '{7,1,8'h80,8'h01},
        '{8,0,8'h80,8'h04}, '{9,0,8'h80,8'h08}, '{10,0,8'h80,8'h10}, '{11,0,8'h80,8'h20},
        '{12,0,8'h80,8'h40}, '{13,0,8'h80,8'h80}, '{14,0,8'h80,8'h02}};
    // Free-running 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    limit_status_alert_unit uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .window_reading(window_reading),
        .window_high(window_high), .window_low(window_low), .tach_period(tach_period),
        .tach_limit(tach_limit), .diode_one_fault(diode_one_fault), .diode_two_fault(diode_two_fault),
        .overtemp_flag(overtemp_flag), .pwm_in(pwm_in), .alert_n(alert_n), .second_pulse_output(pin));
    host_model host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    // Counts, verdict and end of run
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    // Wait n falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    // Raise or drop one source; window limits sit at 10..f0, fan limit 1000
    task automatic set_src(input int s, input bit lo, input bit on);
        if (s < 8) begin
            window_reading[s] = !on ? 8'h80 : (lo ? 8'h10 : 8'hf1);
        end else if (s < 12) begin
            tach_period[s-8] = on ? 16'h1001 : 16'h1000;
        end else if (s == 12) begin
            diode_one_fault = on;
        end else if (s == 13) begin
            diode_two_fault = on;
        end else begin
            overtemp_flag = on;
        end
    endtask : set_src
    // Hang guard, far beyond the expected run of about 470 cycles
    initial begin
        #200000;
        err_total++;
        final_report();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        pwm_in = 1'b0;
        {diode_one_fault, diode_two_fault, overtemp_flag} = 3'h0;
        window_reading = {8{8'h80}};
        window_high    = {8{8'hf0}};
        window_low     = {8{8'h10}};
        tach_period    = {4{16'h0800}};
        tach_limit     = {4{16'h1000}};
        cyc(5);
        rst = 1'b0;
        `CHECK_EQ("alert after reset", 1'b1, alert_n);
        `CHECK_EQ("pin after reset", 1'b0, pin);
        host.rd(`MASK_PRI_ADDR, d1);
        host.rd(`MASK_SEC_ADDR, d2);
        `CHECK_EQ("mask reset", 16'h0000, {d1, d2});
        $display("test reset done");
        // Every source: set, alert, read under fault, clear by read
        foreach (rows[i]) begin
            @(negedge mclk);
            set_src(rows[i].src, rows[i].lo, 1'b1);
            cyc(4);
            `CHECK_EQ("alert on fault", 1'b0, alert_n);
            host.rd(`STATUS_PRI_ADDR, d1);
            host.rd(`STATUS_SEC_ADDR, d2);
            `CHECK_EQ("status pri", rows[i].e1, d1);
            `CHECK_EQ("status sec", rows[i].e2, d2);
            host.rd(`STATUS_PRI_ADDR, d1);
            `CHECK_EQ("sticky under fault", rows[i].e1, d1);
            cyc(4);
            `CHECK_EQ("alert held unread", 1'b0, alert_n);
            set_src(rows[i].src, rows[i].lo, 1'b0);
            cyc(3);
            `CHECK_EQ("alert until read", 1'b0, alert_n);
            host.rd(`STATUS_SEC_ADDR, d2);
            host.rd(`STATUS_PRI_ADDR, d1);
            host.rd(`STATUS_PRI_ADDR, d1);
            host.rd(`STATUS_SEC_ADDR, d2);
            `CHECK_EQ("status cleared", 16'h0000, {d1, d2});
            `CHECK_EQ("alert released", 1'b1, alert_n);
            $display("test source %0d done", rows[i].src);
        end
        // High limit equal is not a violation; read-only and unmapped places
        window_reading[3] = 8'hf0;
        host.wr(`STATUS_PRI_ADDR, 8'hff);
        cyc(3);
        host.rd(`STATUS_PRI_ADDR, d1);
        host.rd(8'h10, d2);
        `CHECK_EQ("high equal, status write", 8'h00, d1);
        `CHECK_EQ("unmapped read", 8'h00, d2);
        window_reading[3] = 8'h80;
        $display("test boundary done");
        // Masking sequence as a host handler would run it
        @(negedge mclk);
        set_src(5, 1'b0, 1'b1);
        cyc(4);
        host.service(d1, d2);
        cyc(3);
        `CHECK_EQ("masked alert", 1'b1, alert_n);
        `CHECK_EQ("service status", 8'h20, d1);
        set_src(13, 1'b0, 1'b1);
        cyc(4);
        host.rd(`STATUS_SEC_ADDR, d2);
        `CHECK_EQ("masked still sets", 8'h80, d2);
        `CHECK_EQ("sec mask gates", 1'b1, alert_n);
        host.wr(`MASK_PRI_ADDR, 8'h7f);
        cyc(3);
        `CHECK_EQ("sec mask disabled", 1'b0, alert_n);
        host.wr(`MASK_PRI_ADDR, 8'hff);
        cyc(3);
        `CHECK_EQ("sec mask enabled", 1'b1, alert_n);
        host.rd(`MASK_PRI_ADDR, d1);
        host.rd(`MASK_SEC_ADDR, d2);
        `CHECK_EQ("mask readback", 16'hffff, {d1, d2});
        set_src(5, 1'b0, 1'b0);
        set_src(13, 1'b0, 1'b0);
        host.poll_unmask(d1);
        host.poll_unmask(d1);
        host.rd(`MASK_PRI_ADDR, d2);
        `CHECK_EQ("unmasked after clear", 16'h0000, {d1, d2});
        $display("test masking done");
        // Shared pin: pulse path by default, alert when selected
        pwm_in = 1'b1;
        cyc(2);
        `CHECK_EQ("pin pulse high", 1'b1, pin);
        pwm_in = 1'b0;
        cyc(2);
        `CHECK_EQ("pin pulse low", 1'b0, pin);
        host.wr(`CONFIG_THREE_ADDR, 8'h01);
        // Pulse input held opposite to the expected pin, so only the alert path can pass
        pwm_in = 1'b0;
        cyc(3);
        `CHECK_EQ("pin idle alert", 1'b1, pin);
        set_src(0, 1'b0, 1'b1);
        pwm_in = 1'b1;
        cyc(5);
        `CHECK_EQ("pin shows alert", 1'b0, pin);
        $display("test pin done");
        final_report();
    end
endmodule : limit_status_alert_unit_tb
`default_nettype wire
